/* File: core/ctu_map.svh */
// Purpose: Numeric constants for the dual counter/timer unit
// Assumes: Included by the package and the top module
// Notes: Definitions only
`ifndef CTU_MAP_SVH
`define CTU_MAP_SVH

// ******************************************
// Time base generation
// ******************************************
// Master clock rate in kHz (40 MHz)
`define CTU_MCLK_KHZ 16'h9c40
// Internal time base rate in kHz (12 MHz)
`define CTU_TB_KHZ 16'h2ee0
`define CTU_ACC_ZERO 16'h0000

// ******************************************
// Counter values
// ******************************************
`define CTU_PH_ZERO 16'h0000
`define CTU_PH_ONE 16'h0001
`define CTU_PH_MAX 16'hffff

// ******************************************
// Synchroniser layout and reset values
// ******************************************
`define CTU_PIN_W 4
`define CTU_PIN_ZERO 4'h0
`define CTU_CLK_BIT0 0
`define CTU_GATE_BIT0 1
`define CTU_OUT_RST 2'h0

`endif

/* File: core/ctu_pkg.sv */
// Purpose: Types shared by the dual counter/timer unit
// Assumes: ctu_map.svh for numeric constants
// Notes: Mode, source, gate and state encodings
`include "ctu_map.svh"

package ctu_pkg;

   typedef enum logic [2:0] {
      CTU_MODE_COUNT = 3'h0,
      CTU_MODE_FREQ = 3'h1,
      CTU_MODE_RATE = 3'h2,
      CTU_MODE_OS = 3'h3,
      CTU_MODE_OSR = 3'h4
   } ctu_mode_t;

   typedef enum logic [1:0] {
      CTU_SRC_INT = 2'h0,
      CTU_SRC_EXT = 2'h1,
      CTU_SRC_CASC = 2'h2
   } ctu_src_t;

   typedef enum logic [2:0] {
      CTU_GATE_NONE = 3'h0,
      CTU_GATE_LOW = 3'h1,
      CTU_GATE_HIGH = 3'h2,
      CTU_GATE_FALL = 3'h3,
      CTU_GATE_RISE = 3'h4
   } ctu_gate_t;

   typedef enum logic [3:0] {
      CTU_ST_IDLE = 4'h1,
      CTU_ST_ARM = 4'h2,
      CTU_ST_RUN = 4'h4,
      CTU_ST_DONE = 4'h8
   } ctu_state_t;

   // Per-channel configuration
   typedef struct packed {
      ctu_mode_t mode;
      ctu_src_t src;
      ctu_gate_t gate;
      logic pol_lh;
      logic [15:0] div_m1;
      logic [15:0] idle_ticks;
   } ctu_cfg_t;

endpackage

/* File: core/ctu_top.sv */
// Purpose: Two 16-bit counter/timer channels with gate and pulse output
// Assumes: 40 MHz I_MCLK; pins asynchronous to it
// Notes: Channel 1 may count channel 0 period ends (32-bit cascade)
//
// Functional notes
// - Two independent sixteen-bit counter channels
// - Each channel: clock, gate in, pulse out
// - Clock source internal, external or cascade
// - Internal 12 MHz base; start on rising edge
// - External clock counts on rising edges only
// - External output equals input over divider
// - Cascade routes channel 0 into channel 1
// - Cascade covers 0.0028 Hz to 6 MHz
// - After gate enable, start on next clock
// - Gate none: software start enables immediately
// - Low level gate runs while pin low
// - High level gate runs while pin high
// - Edge gates trigger one-shot modes only
// - Polarity selects which pulse half is active
// - Duty sets active share of each period
// - Five modes: count, freq, rate, one-shots
// - Event count wraps at 2^16, cascaded 2^32
// - Rate generation continuous until disabled
// - One-shot stops, ignores inputs until start is withdrawn
// - Repetitive one-shot ignores triggers during pulse
`timescale 1ns/100ps
`include "ctu_map.svh"

module ctu_top (
   // Clock and reset
   input wire logic I_MCLK,
   input wire logic I_RESETN,
   // Channel configuration
   input wire ctu_pkg::ctu_cfg_t I_CFG0,
   input wire ctu_pkg::ctu_cfg_t I_CFG1,
   input wire logic [1:0] I_START,
   // Terminal inputs
   input wire logic [1:0] I_CT_CLK,
   input wire logic [1:0] I_CT_GATE,
   // Terminal outputs
   output logic [1:0] O_PULSE,
   // Status
   output logic [15:0] O_COUNT0,
   output logic [15:0] O_COUNT1,
   output logic [1:0] O_RUNNING
);

   // ******************************************
   // Functions
   // ******************************************
   // Level gate decode; edge and none types do not pause
   function automatic logic gate_open(input ctu_pkg::ctu_gate_t g,
                                      input logic lvl);
      logic r;
      r = 1'b1;
      if (g == ctu_pkg::CTU_GATE_LOW) begin
         r = ~lvl;
      end else if (g == ctu_pkg::CTU_GATE_HIGH) begin
         r = lvl;
      end
      return r;
   endfunction

   // Trigger decode for the one-shot modes
   function automatic logic gate_trig(input ctu_pkg::ctu_gate_t g,
                                      input logic rise,
                                      input logic fall);
      logic r;
      r = 1'b0;
      case (g)
         ctu_pkg::CTU_GATE_NONE: r = 1'b1;
         ctu_pkg::CTU_GATE_FALL,
         ctu_pkg::CTU_GATE_LOW: r = fall;
         ctu_pkg::CTU_GATE_RISE,
         ctu_pkg::CTU_GATE_HIGH: r = rise;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic is_count(input ctu_pkg::ctu_mode_t m);
      return (m == ctu_pkg::CTU_MODE_COUNT) ||
             (m == ctu_pkg::CTU_MODE_FREQ);
   endfunction

   function automatic logic is_shot(input ctu_pkg::ctu_mode_t m);
      return (m == ctu_pkg::CTU_MODE_OS) ||
             (m == ctu_pkg::CTU_MODE_OSR);
   endfunction

   // Phase step, wraps at the counter width
   function automatic logic [15:0] ph_step(input logic [15:0] p);
      return 16'(p + `CTU_PH_ONE);
   endfunction

   // Active part of a period follows the idle ticks
   function automatic logic in_active(input logic [15:0] p,
                                      input logic [15:0] idle);
      return p >= idle;
   endfunction

   // Last tick of the programmed period
   function automatic logic at_end(input logic [15:0] p,
                                   input logic [15:0] last);
      return p == last;
   endfunction

   // ******************************************
   // Internal time base
   // ******************************************
   logic [15:0] acc_q;
   logic [15:0] acc_d;
   logic tb_tick;
   logic [16:0] acc_sum;

   // Fractional accumulator gives 12 ticks per 40 master cycles
   always_comb begin
      acc_sum = {1'b0, acc_q} + {1'b0, `CTU_TB_KHZ};
      tb_tick = 1'b0;
      acc_d = acc_sum[15:0];
      if (acc_sum >= {1'b0, `CTU_MCLK_KHZ}) begin
         tb_tick = 1'b1;
         acc_d = 16'(acc_sum - {1'b0, `CTU_MCLK_KHZ});
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         acc_q <= `CTU_ACC_ZERO;
      end else begin
         acc_q <= acc_d;
      end
   end

   // ******************************************
   // Pin synchronisers
   // ******************************************
   logic [`CTU_PIN_W-1:0] pins;
   logic [`CTU_PIN_W-1:0] s1_q;
   logic [`CTU_PIN_W-1:0] s2_q;
   logic [`CTU_PIN_W-1:0] s3_q;
   logic [`CTU_PIN_W-1:0] f_q;
   logic [`CTU_PIN_W-1:0] f_d;
   logic [`CTU_PIN_W-1:0] p_rise;
   logic [`CTU_PIN_W-1:0] p_fall;

   assign pins = {I_CT_GATE[1], I_CT_CLK[1], I_CT_GATE[0], I_CT_CLK[0]};

   // Filtered level moves only when stages two and three agree
   always_comb begin
      for (int b = 0; b < `CTU_PIN_W; b++) begin
         f_d[b] = (s2_q[b] == s3_q[b]) ? s3_q[b] : f_q[b];
      end
      p_rise = f_d & ~f_q;
      p_fall = ~f_d & f_q;
   end

   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         s1_q <= `CTU_PIN_ZERO;
         s2_q <= `CTU_PIN_ZERO;
         s3_q <= `CTU_PIN_ZERO;
         f_q <= `CTU_PIN_ZERO;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         f_q <= f_d;
      end
   end

   // ******************************************
   // Channels
   // ******************************************
   ctu_pkg::ctu_cfg_t cfg [2];
   ctu_pkg::ctu_state_t st_q [2];
   ctu_pkg::ctu_state_t st_d [2];
   logic [1:0][15:0] ph_q;
   logic [1:0][15:0] ph_d;
   logic [1:0] out_q;
   logic [1:0] out_d;
   logic [1:0] tick;
   logic [1:0] evt;
   logic [1:0] open_g;
   logic [1:0] trig;
   logic [1:0] act;

   assign cfg[0] = I_CFG0;
   assign cfg[1] = I_CFG1;

   always_comb begin
      tick = 2'h0;
      evt = 2'h0;
      open_g = 2'h0;
      trig = 2'h0;
      act = 2'h0;
      for (int i = 0; i < 2; i++) begin
         st_d[i] = st_q[i];
         ph_d[i] = ph_q[i];
         // Clock source select
         case (cfg[i].src)
            ctu_pkg::CTU_SRC_EXT:
               tick[i] = p_rise[2*i+`CTU_CLK_BIT0];
            ctu_pkg::CTU_SRC_CASC:
               tick[i] = (i == 1) ? evt[0] : tb_tick;
            default: tick[i] = tb_tick;
         endcase
         open_g[i] = gate_open(cfg[i].gate,
                               f_q[2*i+`CTU_GATE_BIT0]);
         trig[i] = gate_trig(cfg[i].gate,
                             p_rise[2*i+`CTU_GATE_BIT0],
                             p_fall[2*i+`CTU_GATE_BIT0]);
         case (st_q[i])
            ctu_pkg::CTU_ST_IDLE: begin
               ph_d[i] = `CTU_PH_ZERO;
               if (I_START[i]) begin
                  st_d[i] = is_shot(cfg[i].mode) ?
                     ctu_pkg::CTU_ST_ARM : ctu_pkg::CTU_ST_RUN;
               end
            end
            ctu_pkg::CTU_ST_ARM: begin
               ph_d[i] = `CTU_PH_ZERO;
               if (!I_START[i]) begin
                  st_d[i] = ctu_pkg::CTU_ST_IDLE;
               end else if (trig[i]) begin
                  st_d[i] = ctu_pkg::CTU_ST_RUN;
               end
            end
            ctu_pkg::CTU_ST_RUN: begin
               if (!I_START[i]) begin
                  st_d[i] = ctu_pkg::CTU_ST_IDLE;
               end else if (is_count(cfg[i].mode)) begin
                  // Count only on clocks while the gate is open
                  if (open_g[i] && tick[i]) begin
                     ph_d[i] = ph_step(ph_q[i]);
                     evt[i] = (ph_q[i] == `CTU_PH_MAX);
                  end
               end else if (cfg[i].mode == ctu_pkg::CTU_MODE_RATE) begin
                  act[i] = open_g[i] &&
                     in_active(ph_q[i], cfg[i].idle_ticks);
                  if (open_g[i] && tick[i]) begin
                     evt[i] = at_end(ph_q[i], cfg[i].div_m1);
                     ph_d[i] = evt[i] ? `CTU_PH_ZERO :
                        ph_step(ph_q[i]);
                  end
               end else begin
                  act[i] = in_active(ph_q[i], cfg[i].idle_ticks);
                  // Triggers are not looked at while the pulse runs
                  if (tick[i]) begin
                     evt[i] = at_end(ph_q[i], cfg[i].div_m1);
                     ph_d[i] = ph_step(ph_q[i]);
                     if (evt[i]) begin
                        ph_d[i] = `CTU_PH_ZERO;
                        st_d[i] = (cfg[i].mode == ctu_pkg::CTU_MODE_OS) ?
                           ctu_pkg::CTU_ST_DONE :
                           ctu_pkg::CTU_ST_ARM;
                     end
                  end
               end
            end
            ctu_pkg::CTU_ST_DONE: begin
               // Held until software withdraws the start
               if (!I_START[i]) begin
                  st_d[i] = ctu_pkg::CTU_ST_IDLE;
               end
            end
            default: st_d[i] = ctu_pkg::CTU_ST_IDLE;
         endcase
         out_d[i] = cfg[i].pol_lh ? act[i] : ~act[i];
         if (st_d[i] == ctu_pkg::CTU_ST_IDLE) begin
            out_d[i] = ~cfg[i].pol_lh;
         end
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         st_q[0] <= ctu_pkg::CTU_ST_IDLE;
         st_q[1] <= ctu_pkg::CTU_ST_IDLE;
         ph_q <= {`CTU_PH_ZERO, `CTU_PH_ZERO};
         // Polarity unknown in reset; idle level from first edge
         out_q <= `CTU_OUT_RST;
      end else begin
         st_q <= st_d;
         ph_q <= ph_d;
         out_q <= out_d;
      end
   end

   // ******************************************
   // Outputs
   // ******************************************
   assign O_PULSE = out_q;
   assign O_COUNT0 = ph_q[0];
   assign O_COUNT1 = ph_q[1];
   assign O_RUNNING[0] = (st_q[0] == ctu_pkg::CTU_ST_RUN);
   assign O_RUNNING[1] = (st_q[1] == ctu_pkg::CTU_ST_RUN);

endmodule // ctu_top

/* File: bench/ctu_ext_clk.sv */
// Purpose: Terminal clock source for one counter channel
// Assumes: Bench clock drives the timing
// Notes: Pin rests low between bursts
`timescale 1ns/100ps
module ctu_ext_clk (
   // Clock
   input wire logic i_clk,
   // Terminal pin
   output logic o_pin
);
   initial o_pin = 1'b0;

   // ******************************************
   // Burst of rising edges, then rest low
   // ******************************************
   task automatic burst(input int n, input int half);
      repeat (n) begin
         repeat (half) @(negedge i_clk);
         o_pin = 1'b1;
         repeat (half) @(negedge i_clk);
         o_pin = 1'b0;
      end
   endtask
endmodule // ctu_ext_clk

/* File: bench/ctu_top_properties.sv */
// Purpose: Port checker for the counter/timer unit
// Assumes: Sees only the top module ports
// Notes: Channel 0 is watched closely, channel 1 in cascade
`timescale 1ns/100ps
module ctu_chk (
   // Clock and reset
   input wire logic I_MCLK,
   input wire logic I_RESETN,
   // Configuration
   input wire ctu_pkg::ctu_cfg_t I_CFG0,
   input wire ctu_pkg::ctu_cfg_t I_CFG1,
   input wire logic [1:0] I_START,
   // Terminals
   input wire logic [1:0] I_CT_CLK,
   input wire logic [1:0] I_CT_GATE,
   input wire logic [1:0] O_PULSE,
   // Status
   input wire logic [15:0] O_COUNT0,
   input wire logic [15:0] O_COUNT1,
   input wire logic [1:0] O_RUNNING
);
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RESETN);
   wire is_cnt = I_CFG0.mode == ctu_pkg::CTU_MODE_COUNT;
   wire is_rate = I_CFG0.mode == ctu_pkg::CTU_MODE_RATE;
   wire is_os = I_CFG0.mode == ctu_pkg::CTU_MODE_OS;
   wire hold0 = is_cnt && I_CFG0.gate == ctu_pkg::CTU_GATE_HIGH;
   wire casc1 = I_CFG1.src == ctu_pkg::CTU_SRC_CASC;

   // ******************************************
   // Properties
   // ******************************************
   AST_RST_IDLE: assert property (
      $rose(I_RESETN) |-> O_RUNNING == 2'h0 && O_PULSE == 2'h0)
      else $error("outputs not idle after reset");
   AST_STOP: assert property (
      !I_START[0] |=> !O_RUNNING[0])
      else $error("channel runs without start");
   AST_START_RATE: assert property (
      I_START[0] && !O_RUNNING[0] && is_rate &&
      I_CFG0.gate == ctu_pkg::CTU_GATE_NONE |=> O_RUNNING[0])
      else $error("rate start not taken");
   AST_IDLE_LVL: assert property (
      is_cnt |=> O_PULSE[0] == !$past(I_CFG0.pol_lh))
      else $error("count mode pulse not idle");
   AST_RATE_IDLE: assert property (
      is_rate && !O_RUNNING[0] && !$past(O_RUNNING[0])
      |=> O_PULSE[0] == !$past(I_CFG0.pol_lh))
      else $error("stopped rate output not idle");
   AST_CNT_STEP: assert property (
      O_RUNNING[0] && $past(O_RUNNING[0]) && is_cnt &&
      $changed(O_COUNT0) |-> O_COUNT0 == $past(O_COUNT0) + 16'h0001)
      else $error("event count did not step by one");
   AST_GATE_HOLD: assert property (
      (O_RUNNING[0] && hold0 && !I_CT_GATE[0])[*6]
      |=> $stable(O_COUNT0))
      else $error("count moved with gate closed");
   AST_OS_DONE: assert property (
      ($fell(O_RUNNING[0]) && I_START[0] && is_os) ##1 I_START[0][*8]
      |-> !O_RUNNING[0])
      else $error("one-shot restarted");
   AST_CASC: assert property (
      casc1 && O_RUNNING[1] && $past(O_RUNNING[1]) &&
      $changed(O_COUNT1) |-> O_COUNT0 <= 16'h0001)
      else $error("cascade tick not at channel 0 period end");

   COV_RATE: cover property ($rose(O_PULSE[0]) && is_rate);
   COV_OS: cover property ($fell(O_RUNNING[0]) && is_os);
   COV_CASC: cover property ($changed(O_COUNT1) && casc1);
endmodule // ctu_chk

bind ctu_top ctu_chk i_chk (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN),
   .I_CFG0(I_CFG0), .I_CFG1(I_CFG1), .I_START(I_START),
   .I_CT_CLK(I_CT_CLK), .I_CT_GATE(I_CT_GATE), .O_PULSE(O_PULSE),
   .O_COUNT0(O_COUNT0), .O_COUNT1(O_COUNT1), .O_RUNNING(O_RUNNING));

/* File: bench/tb_ctu_top.sv */
// Purpose: Self-checking bench for the counter/timer unit
// Assumes: Inputs change at the falling clock edge
// Notes: A monitor tallies pulse rises and high time
`timescale 1ns/100ps
module tb_ctu_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   ctu_pkg::ctu_cfg_t cfg0, cfg1;
   logic [1:0] start = 2'h0;
   logic [1:0] gate = 2'h0;
   logic [1:0] pp = 2'h0;
   wire [1:0] ct_clk, pulse, run;
   wire [15:0] cnt0, cnt1;
   int fails = 0;
   int comparisons = 0;
   int r0 = 0, r1 = 0, h0 = 0, b, c;

   always #12.5 clk = ~clk;
   ctu_top i_dut (.I_MCLK(clk), .I_RESETN(rst_n), .I_CFG0(cfg0),
      .I_CFG1(cfg1), .I_START(start), .I_CT_CLK(ct_clk),
      .I_CT_GATE(gate), .O_PULSE(pulse), .O_COUNT0(cnt0),
      .O_COUNT1(cnt1), .O_RUNNING(run));
   ctu_ext_clk i_ext0 (.i_clk(clk), .o_pin(ct_clk[0]));
   ctu_ext_clk i_ext1 (.i_clk(clk), .o_pin(ct_clk[1]));

   // ******************************************
   // Helpers
   // ******************************************
   always @(posedge clk) begin
      r0 <= r0 + int'(pulse[0] & ~pp[0]);
      r1 <= r1 + int'(pulse[1] & ~pp[1]);
      h0 <= h0 + int'(pulse[0]);
      pp <= pulse;
   end

   // Mode, source and gate given as codes
   function automatic ctu_pkg::ctu_cfg_t mk(input logic [2:0] m,
      input logic [1:0] s, input logic [2:0] g, input logic p,
      input logic [15:0] d, input logic [15:0] i);
      mk = '{ctu_pkg::ctu_mode_t'(m), ctu_pkg::ctu_src_t'(s),
         ctu_pkg::ctu_gate_t'(g), p, d, i};
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      cyc(20000);
      fails++;
      end_of_test();
   end

   // ******************************************
   // Tests
   // ******************************************
   initial begin
      cfg0 = mk(3'h0, 2'h1, 3'h2, 1'b1, 16'h0000, 16'h0000);
      cfg1 = mk(3'h2, 2'h1, 3'h2, 1'b0, 16'h0003, 16'h0002);
      cyc(6);
      rst_n = 1'b1;
      cyc(2);
      chk(pulse, 2'h2);
      chk({cnt1, cnt0, run}, 34'h0);
      gate[0] = 1'b1;
      start[0] = 1'b1;
      cyc(3);
      i_ext0.burst(10, 4);
      cyc(8);
      chk(cnt0, 16'h000a);
      gate[0] = 1'b0;
      cyc(4);
      i_ext0.burst(5, 4);
      cyc(8);
      chk(cnt0, 16'h000a);
      start[0] = 1'b0;
      cyc(1);
      cfg0.gate = ctu_pkg::CTU_GATE_LOW;
      start[0] = 1'b1;
      cyc(3);
      b = cnt0;
      i_ext0.burst(5, 4);
      cyc(8);
      chk(cnt0 - b, 5);
      start[0] = 1'b0;
      cyc(1);
      cfg0.mode = ctu_pkg::CTU_MODE_FREQ;
      start[0] = 1'b1;
      cyc(3);
      chk(run[0], 1'b1);
      start[0] = 1'b0;
      cyc(1);
      cfg0 = mk(3'h2, 2'h0, 3'h0, 1'b1, 16'h000f, 16'h0008);
      start[0] = 1'b1;
      b = r0;
      c = h0;
      cyc(800);
      chk((r0 - b) inside {[14:16]}, 1);
      chk((h0 - c) inside {[390:410]}, 1);
      start[0] = 1'b0;
      cyc(2);
      c = h0;
      cyc(60);
      chk(h0 - c, 0);
      cfg0.pol_lh = 1'b0;
      cyc(2);
      chk(pulse[0], 1'b1);
      gate[1] = 1'b1;
      start[1] = 1'b1;
      cyc(3);
      b = r1;
      i_ext1.burst(40, 7);
      cyc(8);
      chk(r1 - b, 10);
      start = 2'h0;
      cyc(1);
      cfg0 = mk(3'h2, 2'h0, 3'h0, 1'b1, 16'h000f, 16'h0008);
      cfg1 = mk(3'h2, 2'h2, 3'h0, 1'b1, 16'hffff, 16'h8000);
      start = 2'h3;
      cyc(1334);
      chk(cnt1 inside {[16'h0017:16'h001a]}, 1);
      chk(run, 2'h3);
      start = 2'h0;
      gate[0] = 1'b0;
      cyc(1);
      cfg0 = mk(3'h3, 2'h0, 3'h4, 1'b1, 16'h000f, 16'h0000);
      start[0] = 1'b1;
      b = r0;
      cyc(20);
      chk(r0 - b, 0);
      repeat (2) begin
         gate[0] = 1'b1;
         cyc(80);
         gate[0] = 1'b0;
         cyc(10);
      end
      chk(r0 - b, 1);
      chk(run[0], 1'b0);
      start[0] = 1'b0;
      gate[0] = 1'b1;
      cyc(1);
      cfg0 = mk(3'h4, 2'h0, 3'h3, 1'b1, 16'h001f, 16'h0000);
      start[0] = 1'b1;
      b = r0;
      cyc(6);
      for (int k = 0; k < 3; k++) begin
         gate[0] = 1'b0;
         cyc(k == 0 ? 20 : 150);
         gate[0] = 1'b1;
         cyc(10);
      end
      cyc(150);
      chk(r0 - b, 2);
      end_of_test();
   end
endmodule // tb_ctu_top
